// ---- hdl/osc_startup_timer.sv ----
// Oscillator start-up timer counting main oscillator periods
`timescale 1ns/1ps
`default_nettype none
module osc_startup_timer #(
	parameter int PERIODS = 1024
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic start,
	input wire logic osc_edge,
	output logic done
);
	localparam int CW = $clog2(PERIODS + 1);
	localparam logic [CW-1:0] LAST = CW'(PERIODS - 1);

	if (PERIODS < 1) begin : g_bad_periods
		$error("osc_startup_timer: PERIODS must be at least 1");
	end

	logic busy_reg;
	logic [CW-1:0] cnt_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			busy_reg <= 1'b0;
			cnt_reg <= '0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				busy_reg <= 1'b1;
				cnt_reg <= '0;
			end else if (busy_reg && osc_edge) begin
				if (cnt_reg == LAST) begin
					busy_reg <= 1'b0;
					done <= 1'b1; // R20
				end else begin
					cnt_reg <= cnt_reg + 1'b1;
				end
			end
		end
	end

	chk_done_after_count: assert property (@(posedge clk) disable iff (srst)
		done |-> $past(busy_reg) && $past(osc_edge) && $past(cnt_reg) == LAST) // R20
		else $error("start-up done without full count");
endmodule : osc_startup_timer
`default_nettype wire

// ---- hdl/watchdog_sleep_wake_control.sv ----
// Watchdog timer and sleep / wake-up control with an Avalon-MM register port
// Behaviour
// R1 - Watchdog runs on own oscillator, also asleep
// R2 - Expiry while running resets the device
// R3 - Expiry while asleep wakes, no reset
// R4 - Fuse at zero disables watchdog permanently
// R5 - Base period 18 ms, scaler up to 1:128
// R6 - Clear or sleep resets counter and scaler
// R7 - Expiry clears the time-out flag
// R8 - Sleep entry: clear watchdog, flags, oscillator off
// R9 - Pins keep their state during sleep
// R10 - Watchdog reset never drives reset pin
// R11 - Wake by pin reset, watchdog or interrupt
// R12 - Phase-clocked peripherals cannot interrupt asleep
// R13 - Pin wake resets; other wakes continue
// R14 - Power-down flag set at power-up, cleared sleeping
// R15 - Sleep prefetches the next instruction
// R16 - Enabled sources wake regardless of global enable
// R17 - Global enable set branches to vector after
// R18 - Pending interrupt makes sleep a no-op
// R19 - Late interrupt: finish sleep, then wake
// R20 - Crystal wake waits 1024 periods; RC none
// R21 - Firmware clears watchdog before sleep, adds no-op
// R22 - Flag pair encodes the reset cause
// R23 - Scaler ratio is two to the field
`timescale 1ns/1ps
`default_nettype none
module watchdog_sleep_wake_control import wdt_sleep_pkg::*; #(
	parameter int WDT_CYCLES = WDT_BASE_CYCLES,
	parameter int OST_PERIODS = OST_TOSC_PERIODS
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [15:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic master_reset_pin_n,
	input wire logic main_osc_input,
	input wire logic sleep_op,
	input wire logic kick_watchdog_op,
	input wire logic global_irq_allow,
	input wire logic ext_irq_flag,
	input wire logic ext_irq_enable,
	input wire logic port_change_flag,
	input wire logic port_change_enable,
	input wire logic ee_done_flag,
	input wire logic ee_done_enable,
	output logic device_reset,
	output logic osc_driver_en,
	output logic phase_clock_run,
	output logic io_hold,
	output logic prefetch_next,
	output logic resume_exec,
	output logic branch_to_vector,
	output logic watchdog_expired_flag_n,
	output logic sleep_entered_flag_n
);
	localparam int CW = $clog2(WDT_CYCLES);
	localparam logic [CW-1:0] WDT_LAST = CW'(WDT_CYCLES - 1);

	if (WDT_CYCLES < 2) begin : g_bad_cycles
		$error("watchdog_sleep_wake_control: WDT_CYCLES must be at least 2");
	end

	function automatic logic hits(input logic [15:0] addr, input logic [13:0] idx);
		return addr == {idx, 2'b00};
	endfunction : hits

	// Synchronisers for the pins
	logic rst_pin_meta_reg;
	logic rst_pin_sync_reg;
	logic osc_meta_reg;
	logic osc_sync_reg;
	logic osc_prev_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			rst_pin_meta_reg <= 1'b1;
			rst_pin_sync_reg <= 1'b1;
			osc_meta_reg <= 1'b0;
			osc_sync_reg <= 1'b0;
			osc_prev_reg <= 1'b0;
		end else begin
			rst_pin_meta_reg <= master_reset_pin_n;
			rst_pin_sync_reg <= rst_pin_meta_reg;
			osc_meta_reg <= main_osc_input;
			osc_sync_reg <= osc_meta_reg;
			osc_prev_reg <= osc_sync_reg;
		end
	end

	wire pin_reset = ~rst_pin_sync_reg;
	wire osc_edge = osc_sync_reg & ~osc_prev_reg;

	// Registers
	logic [7:0] option_reg;
	logic [7:0] config_reg;
	logic to_n_reg;
	logic pd_n_reg;
	power_state_t state_reg;
	power_state_t state_next;

	wire watchdog_enable_fuse = config_reg[CFG_WATCHDOG_ENABLE_FUSE_BIT];
	wire [1:0] osc_mode = {config_reg[CFG_OSC_HI_BIT], config_reg[CFG_OSC_LO_BIT]};
	wire rc_mode = (osc_mode == OSC_MODE_RC);
	wire in_run = (state_reg == ST_RUN);
	wire in_sleep = (state_reg == ST_SLEEP);
	wire in_start = (state_reg == ST_START);

	// Only wake-capable sources count; the timer flag needs phase clocks
	wire irq_pending = (ext_irq_flag & ext_irq_enable) | (port_change_flag & port_change_enable)
		| (ee_done_flag & ee_done_enable); // R11 R12 R16

	wire sleep_seen = sleep_op & in_run & ~pin_reset;
	wire sleep_go = sleep_seen & ~irq_pending; // R18
	wire kick = kick_watchdog_op & in_run;

	// Watchdog base counter, advanced on every clk cycle and never by the main oscillator
	logic [CW-1:0] wdt_cnt_reg;
	logic dev_reset_reg;
	wire wdt_clear = kick | sleep_go | pin_reset | dev_reset_reg | ~watchdog_enable_fuse; // R6 R8 R4
	wire base_tick = watchdog_enable_fuse & (wdt_cnt_reg == WDT_LAST); // R1 R5

	always_ff @(posedge clk) begin
		if (srst || wdt_clear || base_tick) begin
			wdt_cnt_reg <= '0; // R6
		end else begin
			wdt_cnt_reg <= wdt_cnt_reg + 1'b1; // R1
		end
	end

	wdt_scaler_if #(.RATIO_W(RATIO_W)) sc ();

	assign sc.tick = base_tick;
	assign sc.clear = wdt_clear; // R6
	assign sc.assigned = option_reg[OPT_OWNER_BIT];
	assign sc.ratio = option_reg[OPT_RATIO_LSB +: RATIO_W]; // R5 R23

	wdt_scaler #(.RATIO_W(RATIO_W)) u_scaler (
		.clk(clk),
		.srst(srst),
		.sc(sc)
	);

	wire wdt_expire = sc.fire & ~wdt_clear & watchdog_enable_fuse; // R4
	wire wake_irq = in_sleep & irq_pending & ~pin_reset; // R19
	wire wake_wdt = in_sleep & wdt_expire & ~pin_reset; // R3
	wire wake = wake_irq | wake_wdt;
	wire run_reset = wdt_expire & in_run; // R2
	wire reset_evt = pin_reset | run_reset;

	logic ost_done;

	osc_startup_timer #(.PERIODS(OST_PERIODS)) u_ost (
		.clk(clk),
		.srst(srst),
		.start(wake & ~rc_mode),
		.osc_edge(osc_edge),
		.done(ost_done)
	);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_RUN: begin
				if (sleep_go) begin
					state_next = ST_SLEEP; // R8
				end
			end
			ST_SLEEP: begin
				if (wake) begin
					state_next = rc_mode ? ST_RUN : ST_START; // R20
				end
			end
			ST_START: begin
				if (ost_done) begin
					state_next = ST_RUN;
				end
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
		if (pin_reset) begin
			state_next = ST_RUN; // R13
		end
	end

	logic woke_irq_reg;
	wire resume_now = (wake & rc_mode) | (in_start & ost_done & ~pin_reset);
	wire woke_by_irq = in_sleep ? wake_irq : woke_irq_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= ST_RUN;
			woke_irq_reg <= 1'b0;
			dev_reset_reg <= 1'b0;
			prefetch_next <= 1'b0;
			resume_exec <= 1'b0;
			branch_to_vector <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (wake) begin
				woke_irq_reg <= wake_irq;
			end
			dev_reset_reg <= reset_evt; // R2 R13
			prefetch_next <= sleep_seen; // R15
			resume_exec <= resume_now; // R3 R13
			branch_to_vector <= resume_now & woke_by_irq & global_irq_allow; // R17
		end
	end

	// Sleep entry masks a same-cycle expiry, so its set of the time-out flag wins
	always_ff @(posedge clk) begin
		if (srst) begin
			to_n_reg <= 1'b1; // R14 R22
			pd_n_reg <= 1'b1; // R14 R22
		end else begin
			if (wdt_expire) begin
				to_n_reg <= 1'b0; // R7 R22
			end else if (sleep_go) begin
				to_n_reg <= 1'b1; // R8
			end
			if (sleep_go) begin
				pd_n_reg <= 1'b0; // R8 R14
			end
		end
	end

	// Avalon-MM slave: one wait state on every access
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic [7:0] status_word;
	wire bus_req = avs_read | avs_write;
	wire take = bus_req & ack_reg;
	wire wr_lane = avs_write & take & avs_byteenable[0];
	wire wr_option = wr_lane & hits(avs_address, IDX_OPTION);
	wire wr_config = wr_lane & hits(avs_address, IDX_CONFIG);

	always_comb begin
		status_word = 8'h00;
		status_word[STAT_TO_BIT] = to_n_reg;
		status_word[STAT_PD_BIT] = pd_n_reg;
		status_word[STAT_SLEEP_BIT] = ~in_run;
	end

	wire [7:0] read_mux = hits(avs_address, IDX_STATUS) ? status_word
		: hits(avs_address, IDX_OPTION) ? option_reg
		: hits(avs_address, IDX_CONFIG) ? config_reg
		: 8'h00;

	always_ff @(posedge clk) begin
		if (srst) begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= bus_req & ~ack_reg;
			if (avs_read && !ack_reg) begin
				rdata_reg <= {24'h00_0000, read_mux};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst || reset_evt) begin
			option_reg <= OPTION_RESET;
		end else if (wr_option) begin
			option_reg <= avs_writedata[7:0];
		end
	end

	// Fuses survive pin and watchdog resets
	always_ff @(posedge clk) begin
		if (srst) begin
			config_reg <= CONFIG_RESET;
		end else if (wr_config) begin
			config_reg <= avs_writedata[7:0];
		end
	end

	assign avs_waitrequest = bus_req & ~ack_reg;
	assign avs_readdata = rdata_reg;
	// The reset pin is input only, so a watchdog reset stays internal
	assign device_reset = dev_reset_reg; // R10
	assign osc_driver_en = ~in_sleep; // R8
	assign phase_clock_run = in_run; // R12
	assign io_hold = ~in_run; // R9
	assign watchdog_expired_flag_n = to_n_reg;
	assign sleep_entered_flag_n = pd_n_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_sleep_entry;
		sleep_go ##1 in_sleep && !osc_driver_en;
	endsequence

	sequence s_crystal_wait;
		in_start && !resume_exec;
	endsequence

	chk_fuse_off_quiet: assert property (!watchdog_enable_fuse |-> !wdt_expire ##1 wdt_cnt_reg == '0) // R4
		else $error("watchdog expired with fuse off");
	chk_expiry_to_flag: assert property (wdt_expire |=> !to_n_reg) // R7
		else $error("time-out flag not cleared on expiry");
	chk_run_expiry_reset: assert property (wdt_expire && in_run |=> device_reset) // R2
		else $error("running expiry gave no reset");
	chk_sleep_wdt_wake: assert property (wake_wdt |=> !in_sleep && !device_reset) // R3
		else $error("asleep expiry did not wake cleanly");
	chk_sleep_entry_flags: assert property (s_sleep_entry |-> !pd_n_reg && to_n_reg) // R8
		else $error("sleep entry flags wrong");
	chk_entry_clears_count: assert property (sleep_go |=> wdt_cnt_reg == '0) // R6
		else $error("sleep entry did not clear watchdog");
	chk_pending_noop: assert property (sleep_seen && irq_pending |=> in_run && $stable(pd_n_reg)) // R18
		else $error("sleep with pending interrupt was not a no-op");
	chk_rc_no_delay: assert property (wake && rc_mode |=> in_run && resume_exec) // R20
		else $error("RC wake was delayed");
	chk_crystal_delay: assert property (wake && !rc_mode |=> s_crystal_wait) // R20
		else $error("crystal wake skipped start-up delay");
	chk_vector_branch: assert property (branch_to_vector |-> resume_exec && $past(global_irq_allow)) // R17
		else $error("vector branch without global enable");
	chk_irq_wake: assert property (wake_irq |=> !in_sleep) // R16 R19
		else $error("enabled interrupt did not wake");
	chk_bus_one_wait: assert property (bus_req && !ack_reg |=> !avs_waitrequest || !bus_req)
		else $error("bus answer took more than one wait state");
	// Only the start-up count or a pin reset may end the crystal wait
	chk_start_holds: assert property (in_start && !ost_done && !pin_reset |=> in_start) // R20
		else $error("start-up wait ended early");
	chk_pin_forces_run: assert property (pin_reset |=> in_run && device_reset) // R13
		else $error("pin reset did not reset the device");
	chk_sleep_prefetch: assert property (sleep_seen |=> prefetch_next) // R15
		else $error("sleep gave no prefetch");
	chk_kick_clears: assert property (kick |=> wdt_cnt_reg == '0) // R6
		else $error("watchdog clear did not clear the count");
	// A same-cycle register write must lose against the reset
	chk_option_reload: assert property (reset_evt |=> option_reg == OPTION_RESET) // R2 R13
		else $error("option not reloaded on reset");
endmodule : watchdog_sleep_wake_control
`default_nettype wire

// ---- hdl/wdt_scaler.sv ----
// Watchdog scaler multiplying the base time-out by a power of two
`timescale 1ns/1ps
`default_nettype none
module wdt_scaler import wdt_sleep_pkg::*; #(
	parameter int RATIO_W = 3
) (
	input wire logic clk,
	input wire logic srst,
	wdt_scaler_if.scaler sc
);
	localparam int CNT_W = (1 << RATIO_W) - 1;

	if (RATIO_W < 1 || RATIO_W > 4) begin : g_bad_width
		$error("wdt_scaler: RATIO_W out of range");
	end

	function automatic logic [CNT_W-1:0] limit_of(input logic [RATIO_W-1:0] r);
		logic [CNT_W-1:0] m;
		m = '0;
		for (int i = 0; i < CNT_W; i++) begin
			m[i] = (i < int'(r));
		end
		return m;
	endfunction : limit_of

	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	wire [CNT_W-1:0] limit = limit_of(sc.ratio);

	// Unassigned scaler passes every base tick straight through
	// A ratio lowered mid-count fires on the next base tick instead of wrapping the counter
	assign sc.fire = sc.tick & (~sc.assigned | (cnt_reg >= limit)); // R23
	assign cnt_next = sc.fire ? '0 : cnt_reg + 1'b1;

	always_ff @(posedge clk) begin
		if (srst || sc.clear) begin
			cnt_reg <= '0; // R6
		end else if (sc.tick && sc.assigned) begin
			cnt_reg <= cnt_next;
		end
	end

	chk_unity_ratio: assert property (@(posedge clk) disable iff (srst)
		sc.tick && sc.assigned && sc.ratio == '0 |-> sc.fire) // R23
		else $error("ratio 1:1 did not fire on every tick");
endmodule : wdt_scaler
`default_nettype wire

// ---- hdl/wdt_scaler_if.sv ----
// Signals between the watchdog counter and its scaler
`timescale 1ns/1ps
`default_nettype none
interface wdt_scaler_if #(parameter int RATIO_W = 3);
	logic tick;
	logic clear;
	logic assigned;
	logic [RATIO_W-1:0] ratio;
	logic fire;
	modport owner (output tick, output clear, output assigned, output ratio, input fire);
	modport scaler (input tick, input clear, input assigned, input ratio, output fire);
endinterface : wdt_scaler_if
`default_nettype wire

// ---- hdl/wdt_sleep_pkg.sv ----
// Constants, register map and state encoding for the watchdog and sleep control
package wdt_sleep_pkg;
	localparam int CLK_MHZ = 250;
	localparam int WDT_PERIOD_US = 18000;
	localparam int WDT_BASE_CYCLES = WDT_PERIOD_US * CLK_MHZ;
	localparam int OST_TOSC_PERIODS = 1024;
	localparam int RATIO_W = 3;

	localparam logic [13:0] IDX_STATUS = 14'h0003;
	localparam logic [13:0] IDX_OPTION = 14'h0081;
	localparam logic [13:0] IDX_CONFIG = 14'h2007;

	localparam int OPT_OWNER_BIT = 3;
	localparam int OPT_RATIO_LSB = 0;
	localparam logic [7:0] OPTION_RESET = 8'hff;

	localparam int CFG_PWRT_BIT = 3;
	localparam int CFG_WATCHDOG_ENABLE_FUSE_BIT = 2;
	localparam int CFG_OSC_HI_BIT = 1;
	localparam int CFG_OSC_LO_BIT = 0;
	localparam logic [7:0] CONFIG_RESET = 8'h0f;
	localparam logic [1:0] OSC_MODE_RC = 2'h3;

	localparam int STAT_TO_BIT = 4;
	localparam int STAT_PD_BIT = 3;
	localparam int STAT_SLEEP_BIT = 0;

	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_SLEEP = 2'b01,
		ST_START = 2'b10
	} power_state_t;
endpackage : wdt_sleep_pkg

// ---- verification/core_model.sv ----
// Processor core model issuing sleep and watchdog-clear instructions
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input wire logic clk,
	output logic sleep_op,
	output logic kick_watchdog_op
);
	initial begin
		sleep_op = 1'b0;
		kick_watchdog_op = 1'b0;
	end
	// One-cycle instruction strobe, raised and dropped on rising edges
	task automatic pulse(input logic slp);
		@(posedge clk);
		if (slp) begin
			sleep_op <= 1'b1;
		end else begin
			kick_watchdog_op <= 1'b1;
		end
		@(posedge clk);
		sleep_op <= 1'b0;
		kick_watchdog_op <= 1'b0;
	endtask : pulse
	// Firmware habit: a sleep taken as a no-op would otherwise leave a stale watchdog count running
	task automatic safe_sleep();
		pulse(1'b0);
		pulse(1'b1);
	endtask : safe_sleep
endmodule : core_model
`default_nettype wire

// ---- verification/watchdog_sleep_wake_control_bench.sv ----
// Self-checking bench for the watchdog and sleep control
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
	$display("BAD %0t got %h exp %h", $time, a, b); end end
module watchdog_sleep_wake_control_bench import wdt_sleep_pkg::*;;
	localparam int WDT = 16;
	localparam int OST = 4;
	logic clk = 1'b0;
	logic srst, rd_s, wr_s, mrst_n, gia;
	logic [15:0] adr;
	logic [31:0] wd, rdata;
	logic [3:0] be;
	logic [2:0] fl, en;
	logic [1:0] oc = 2'h0;
	logic wait_r, dev_rst, osc_en, phase, hold, pf, resume, branch, to_n, pd_n, sleep_op, kick;
	wire logic osc;
	int bad_count = 0;
	int checks = 0;
	int seed = 32'h829a;
	int rst_seen = 0;
	int pf_seen = 0;
	assign osc = oc[1];
	always #2 clk = ~clk;
	always @(posedge clk) begin
		oc <= oc + 2'h1;
		if (dev_rst === 1'b1) rst_seen++;
		if (pf === 1'b1) pf_seen++;
	end
	watchdog_sleep_wake_control #(.WDT_CYCLES(WDT), .OST_PERIODS(OST))
		watchdog_sleep_wake_control_i (
		.clk(clk), .srst(srst), .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s),
		.avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wait_r),
		.master_reset_pin_n(mrst_n), .main_osc_input(osc), .sleep_op(sleep_op),
		.kick_watchdog_op(kick), .global_irq_allow(gia), .ext_irq_flag(fl[0]),
		.ext_irq_enable(en[0]), .port_change_flag(fl[1]), .port_change_enable(en[1]),
		.ee_done_flag(fl[2]), .ee_done_enable(en[2]), .device_reset(dev_rst),
		.osc_driver_en(osc_en), .phase_clock_run(phase), .io_hold(hold), .prefetch_next(pf),
		.resume_exec(resume), .branch_to_vector(branch), .watchdog_expired_flag_n(to_n),
		.sleep_entered_flag_n(pd_n));
	core_model core_model_i (.clk(clk), .sleep_op(sleep_op), .kick_watchdog_op(kick));
	function automatic logic [7:0] st(input logic t, input logic p, input logic s);
		return {3'h0, t, p, 2'h0, s};
	endfunction : st
	task automatic end_of_test();
		$display("mismatches %0d checks %0d", bad_count, checks);
		if (bad_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	task automatic give_up(input int got, input int lim);
		bad_count++;
		$display("BAD %0t got %h exp %h", $time, got, lim);
		end_of_test();
	endtask : give_up
	task automatic bus(input logic w, input logic [13:0] idx, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		@(posedge clk);
		adr <= {idx, 2'b00};
		rd_s <= ~w;
		wr_s <= w;
		wd <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wait_r !== 1'b0 && n < 50);
		q = rdata[7:0];
		rd_s <= 1'b0;
		wr_s <= 1'b0;
		if (n >= 50) give_up(n, 50);
	endtask : bus
	// Pulses are sampled at the edge, before that edge's updates land
	task automatic waitfor(input int sel, input int lim, output int n);
		n = 0;
		while (n < lim && !((sel == 0) ? dev_rst === 1'b1 : resume === 1'b1)) begin
			@(posedge clk);
			n++;
		end
		if (n >= lim) give_up(n, lim);
	endtask : waitfor
	initial begin
		logic [7:0] v;
		int n, r, s;
		srst = 1'b1;
		adr = 16'h0;
		rd_s = 1'b0;
		wr_s = 1'b0;
		wd = 32'h0;
		be = 4'h1;
		mrst_n = 1'b1;
		gia = 1'b0;
		fl = 3'h0;
		en = 3'h0;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		bus(1'b0, IDX_OPTION, 8'h00, v); `CHK(v, OPTION_RESET)
		bus(1'b0, IDX_CONFIG, 8'h00, v); `CHK(v, CONFIG_RESET)
		bus(1'b1, IDX_STATUS, 8'h00, v);
		bus(1'b0, IDX_STATUS, 8'h00, v); `CHK(v, st(1'b1, 1'b1, 1'b0))
		bus(1'b0, 14'h0010, 8'h00, v); `CHK(v, 8'h00)
		// A write with lane 0 disabled must leave the option register alone
		be <= 4'h0;
		bus(1'b1, IDX_OPTION, 8'h00, v);
		be <= 4'h1;
		bus(1'b0, IDX_OPTION, 8'h00, v); `CHK(v, OPTION_RESET)
		// Mid-period kick must clear the scaler too, else expiry comes early
		r = {$random(seed)} % 3;
		bus(1'b1, IDX_OPTION, 8'h08 | r[7:0], v);
		core_model_i.pulse(1'b0);
		repeat ((WDT << r) / 2) @(posedge clk);
		core_model_i.pulse(1'b0);
		waitfor(0, 600, n); `CHK(n >= (WDT << r) - 3 && n <= (WDT << r) + 3, 1'b1)
		`CHK(to_n, 1'b0)
		bus(1'b0, IDX_OPTION, 8'h00, v); `CHK(v, OPTION_RESET)
		en <= 3'h1;
		fl <= 3'h1;
		s = pf_seen;
		core_model_i.pulse(1'b1);
		repeat (2) @(posedge clk);
		`CHK(pd_n, 1'b1)
		`CHK(osc_en, 1'b1)
		`CHK(pf_seen, s + 1)
		fl <= 3'h0;
		for (int i = 0; i < 3; i++) begin
			gia <= 1'($random(seed));
			en <= 3'h1 << i;
			core_model_i.safe_sleep();
			repeat (3) @(posedge clk);
			`CHK(osc_en, 1'b0)
			`CHK(hold, 1'b1)
			`CHK(phase, 1'b0)
			bus(1'b0, IDX_STATUS, 8'h00, v); `CHK(v, st(1'b1, 1'b0, 1'b1))
			fl <= 3'h1 << i;
			waitfor(1, 50, n); `CHK(branch, gia)
			`CHK(dev_rst, 1'b0)
			fl <= 3'h0;
		end
		bus(1'b1, IDX_OPTION, 8'h08, v);
		en <= 3'h0;
		fl <= 3'h7;
		s = rst_seen;
		core_model_i.pulse(1'b1);
		waitfor(1, 100, n); `CHK(n >= WDT - 3, 1'b1)
		fl <= 3'h0;
		core_model_i.pulse(1'b0);
		`CHK(rst_seen, s)
		bus(1'b0, IDX_STATUS, 8'h00, v); `CHK(v, st(1'b0, 1'b0, 1'b0))
		bus(1'b1, IDX_CONFIG, 8'h08, v);
		s = rst_seen;
		repeat (100) @(posedge clk);
		`CHK(rst_seen, s)
		// Crystal mode: wake must wait for the start-up count of oscillator edges
		en <= 3'h1;
		core_model_i.pulse(1'b1);
		repeat (2) @(posedge clk);
		fl <= 3'h1;
		waitfor(1, 200, n); `CHK(n >= OST * 4 - 4, 1'b1)
		fl <= 3'h0;
		// Pin reset taken from sleep: device resets and leaves sleep
		core_model_i.pulse(1'b1);
		mrst_n <= 1'b0;
		repeat (6) @(posedge clk);
		`CHK(dev_rst, 1'b1)
		`CHK(osc_en, 1'b1)
		mrst_n <= 1'b1;
		repeat (8) @(posedge clk);
		bus(1'b0, IDX_STATUS, 8'h00, v); `CHK(v, st(1'b1, 1'b0, 1'b0))
		bus(1'b0, IDX_OPTION, 8'h00, v); `CHK(v, OPTION_RESET)
		end_of_test();
	end
endmodule : watchdog_sleep_wake_control_bench
`default_nettype wire
